//--- logic/clock_power_mode_control.v
// Clock source selection and low-power mode sequencing with AHB-Lite regs.
// Assumes the crystal clock arrives as a synchronised level on xtal_clk_in
// and that wake and boot pins are synchronous to clock.
//
// How it works
// RULE1: After reset or wake the processor runs at once from the RC source.
// RULE2: The crystal is enabled alongside and a counter times its settling.
// RULE3: If the crystal input stops the clock falls back to RC and irqs.
// RULE4: Run mode picks PLL and prescalers within flash or SRAM limits.
// RULE5: A 48 MHz USB clock is taken from the PLL alongside the others.
// RULE6: Slow mode lowers the clock, optionally to a low-power source; without the slow low-power option it keeps the run clock.
// RULE7: Peripheral gating mode turns off clocks of unused peripherals.
// RULE8: Wait mode stops only the processor clock until a peripheral irq.
// RULE9: Stop mode halts all clocks, oscillators optional, state kept.
// RULE10: Stop is left on an external wake line or real-time clock event.
// RULE11: Stop may keep oscillator, flash or main regulator enabled.
// RULE12: Standby only in single supply, core off, only RTC powered.
// RULE13: Standby returns to run on the standby pin or an RTC alarm.
// RULE14: With the regulator disable pin high the regulators stay off.
// RULE15: Boot pins are sampled at start-up to choose the boot source.
// RULE16: Software enters modes by register; only wake events leave wait, stop and standby.
`timescale 1ns/1ps
`include "clock_power_regs.vh"

module clock_power_mode_control (
    // Clock and reset
    input  wire        clock,
    input  wire        resetn,
    // AHB-Lite slave
    input  wire        hsel,
    input  wire [11:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    // Oscillators and wake sources
    input  wire        xtal_clk_in,
    input  wire        pll_locked,
    input  wire        periph_irq,
    input  wire        ext_wakeup,
    input  wire        rtc_event,
    input  wire        standby_wakeup_pin,
    input  wire        regulator_disable_pin,
    input  wire [1:0]  boot_pins,
    // Clock controls
    output reg         xtal_osc_en,
    output reg         pll_en,
    output reg  [3:0]  pll_mul,
    output reg  [1:0]  sys_clk_src,
    output reg  [1:0]  ahb_div,
    output reg  [1:0]  apb_div,
    output reg  [2:0]  usb_div,
    output reg         usb_clk_en,
    output reg         cpu_clk_en,
    output reg         periph_clk_en,
    output reg  [7:0]  apb_clk_gate_en,
    output reg         flash_en,
    output reg         main_reg_en,
    output reg         lp_reg_en,
    output reg         core_power_en,
    output reg         rtc_run,
    output reg  [1:0]  boot_sel,
    output reg         irq
);

    localparam [5:0] ST_RUN  = 6'h01;
    localparam [5:0] ST_SLOW = 6'h02;
    localparam [5:0] ST_PCG  = 6'h04;
    localparam [5:0] ST_WFI  = 6'h08;
    localparam [5:0] ST_STOP = 6'h10;
    localparam [5:0] ST_STBY = 6'h20;

    reg  [5:0]  state_ff;
    reg  [5:0]  nxt_state;
    reg  [8:0]  mode_ctrl_ff;
    reg  [13:0] clk_cfg_ff;
    reg  [7:0]  pclk_gate_ff;
    reg  [15:0] stab_limit_ff;
    reg  [15:0] stab_cnt_ff;
    reg         xtal_ok_ff;
    reg  [7:0]  miss_cnt_ff;
    reg         xtal_prev_ff;
    reg  [2:0]  irq_stat_ff;
    reg  [2:0]  irq_mask_ff;
    reg         boot_done_ff;
    reg         ph_valid_ff;
    reg         ph_write_ff;
    reg  [11:0] ph_addr_ff;
    reg  [31:0] rdata;

    wire        ap_take = hsel & hready & htrans[1];
    wire        wr_en   = ph_valid_ff & ph_write_ff;
    wire        wake    = ext_wakeup | rtc_event;
    wire        go_req  = wr_en && ph_addr_ff == `OFS_MODE_CTRL &&
                          hwdata[`MODE_GO_BIT];
    wire [2:0]  go_mode = hwdata[`MODE_SEL_LSB +: `MODE_SEL_W];
    wire        xtal_edge = xtal_clk_in ^ xtal_prev_ff;
    wire        xtal_fail = xtal_ok_ff &&
                            miss_cnt_ff == `XTAL_MISS_CYC;
    // Reached or passed: a limit lowered mid-count still ends settling
    wire        stab_done = xtal_osc_en & ~xtal_ok_ff &
                            (stab_cnt_ff >= stab_limit_ff);
    wire        stop_like = state_ff[4] | state_ff[5];
    reg  [2:0]  irq_set;

    // AHB-Lite address phase capture; always zero wait, OKAY
    always @(posedge clock) begin
        if (!resetn) begin
            ph_valid_ff <= 1'b0;
            ph_write_ff <= 1'b0;
            ph_addr_ff  <= 12'h000;
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
        end else begin
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
            if (hready) begin
                ph_valid_ff <= ap_take;
                ph_write_ff <= hwrite;
                ph_addr_ff  <= haddr;
            end
        end
    end

    always @* begin
        case (haddr)
            `OFS_MODE_CTRL:  rdata = {23'h0, mode_ctrl_ff};
            `OFS_CLK_CFG:    rdata = {18'h0, clk_cfg_ff};
            `OFS_PCLK_GATE:  rdata = {24'h0, pclk_gate_ff};
            `OFS_STATUS:     rdata = {19'h0, boot_done_ff, boot_sel,
                                      regulator_disable_pin, xtal_ok_ff,
                                      sys_clk_src, state_ff};
            `OFS_IRQ_STATUS: rdata = {29'h0, irq_stat_ff};
            `OFS_IRQ_MASK:   rdata = {29'h0, irq_mask_ff};
            `OFS_XTAL_STAB:  rdata = {16'h0, stab_limit_ff};
            default:         rdata = 32'h0000_0000;
        endcase
    end

    // Read data registered at address phase so it stands in data phase
    always @(posedge clock) begin
        if (!resetn)
            hrdata <= 32'h0000_0000;
        else if (ap_take & ~hwrite)
            hrdata <= rdata;
    end

    // Software registers
    always @(posedge clock) begin
        if (!resetn) begin
            mode_ctrl_ff  <= 9'h000;
            clk_cfg_ff    <= `CLK_CFG_RST;
            pclk_gate_ff  <= `PCLK_GATE_RST;
            stab_limit_ff <= `XTAL_STAB_RST;
            irq_mask_ff   <= 3'h0;
        end else if (wr_en) begin
            case (ph_addr_ff)
                // RULE16: mode entry by write
                `OFS_MODE_CTRL: mode_ctrl_ff <= {hwdata[8:1], 1'b0};
                `OFS_CLK_CFG:   clk_cfg_ff   <= hwdata[13:0];
                `OFS_PCLK_GATE: pclk_gate_ff <= hwdata[7:0];
                `OFS_IRQ_MASK:  irq_mask_ff  <= hwdata[2:0];
                `OFS_XTAL_STAB: stab_limit_ff <= hwdata[15:0];
                default: ;
            endcase
        end
    end

    // Mode sequencer
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_RUN, ST_SLOW, ST_PCG: begin
                if (go_req) begin
                    case (go_mode)
                        `MODE_SLOW: nxt_state = ST_SLOW;
                        `MODE_PCG:  nxt_state = ST_PCG;
                        `MODE_WFI:  nxt_state = ST_WFI;
                        `MODE_STOP: nxt_state = ST_STOP;
                        // RULE12: standby refused on external supply
                        `MODE_STANDBY: nxt_state = regulator_disable_pin ?
                                                   state_ff : ST_STBY;
                        default: nxt_state = ST_RUN;
                    endcase
                end
            end
            // RULE8: any peripheral irq restarts cpu
            ST_WFI:  if (periph_irq) nxt_state = ST_RUN;
            // RULE10: stop exit on wake line or RTC
            ST_STOP: if (wake) nxt_state = ST_RUN;
            // RULE13: standby exit on pin or RTC alarm
            ST_STBY: if (standby_wakeup_pin | rtc_event) nxt_state = ST_RUN;
            default: nxt_state = ST_RUN;
        endcase
    end

    // Crystal supervision: edge watchdog and settling counter
    always @(posedge clock) begin
        if (!resetn) begin
            xtal_prev_ff <= 1'b0;
            miss_cnt_ff  <= 8'h00;
            stab_cnt_ff  <= 16'h0000;
            xtal_ok_ff   <= 1'b0;
        end else begin
            xtal_prev_ff <= xtal_clk_in;
            if (xtal_edge || !xtal_osc_en)
                miss_cnt_ff <= 8'h00;
            else if (miss_cnt_ff != `XTAL_MISS_CYC)
                miss_cnt_ff <= miss_cnt_ff + 8'h01;
            // RULE2: dedicated settling counter
            if (!xtal_osc_en || xtal_fail)
                stab_cnt_ff <= 16'h0000;
            else if (!xtal_ok_ff && xtal_edge)
                stab_cnt_ff <= stab_cnt_ff + 16'h0001;
            if (!xtal_osc_en || xtal_fail)
                xtal_ok_ff <= 1'b0;
            else if (stab_done)
                xtal_ok_ff <= 1'b1;
        end
    end

    // Clock and power outputs
    always @(posedge clock) begin
        if (!resetn) begin
            state_ff        <= ST_RUN;
            // RULE1: RC source straight after reset
            sys_clk_src     <= `SRC_RC;
            xtal_osc_en     <= 1'b1;
            pll_en          <= 1'b0;
            pll_mul         <= 4'h0;
            ahb_div         <= 2'h0;
            apb_div         <= 2'h0;
            usb_div         <= 3'h0;
            usb_clk_en      <= 1'b0;
            cpu_clk_en      <= 1'b1;
            periph_clk_en   <= 1'b1;
            apb_clk_gate_en <= `PCLK_GATE_RST;
            flash_en        <= 1'b1;
            main_reg_en     <= 1'b0;
            lp_reg_en       <= 1'b0;
            core_power_en   <= 1'b1;
            rtc_run         <= 1'b1;
        end else begin
            state_ff    <= nxt_state;
            pll_mul     <= clk_cfg_ff[`CFG_MUL_LSB +: `CFG_MUL_W];
            ahb_div     <= clk_cfg_ff[`CFG_HDIV_LSB +: 2];
            // RULE4: flash fetch keeps APB at least halved
            apb_div     <= (!clk_cfg_ff[`CFG_SRAM_BIT] &&
                            clk_cfg_ff[`CFG_PDIV_LSB +: 2] == 2'h0) ?
                           2'h1 : clk_cfg_ff[`CFG_PDIV_LSB +: 2];
            usb_div     <= clk_cfg_ff[`CFG_UDIV_LSB +: 3];
            // RULE14: regulators off when pin is high
            main_reg_en <= ~regulator_disable_pin &
                           (~state_ff[4] | mode_ctrl_ff[`MODE_KEEP_REG_BIT]) &
                           ~state_ff[5];
            lp_reg_en   <= ~regulator_disable_pin;
            // RULE12: core supply removed in standby
            core_power_en <= ~state_ff[5];
            // RULE11: flash kept on in stop by option
            flash_en    <= ~stop_like |
                           (state_ff[4] & mode_ctrl_ff[`MODE_KEEP_FLSH_BIT]);
            rtc_run     <= ~state_ff[4] | mode_ctrl_ff[`MODE_RTC_RUN_BIT];
            // RULE8: only the cpu clock stops in wait
            cpu_clk_en  <= ~state_ff[3] & ~stop_like;
            // RULE9: stop and standby halt the peripheral clocks; rtc_run stays on in standby
            periph_clk_en <= ~stop_like;
            // RULE7: per-peripheral APB gating
            apb_clk_gate_en <= stop_like ? 8'h00 :
                               state_ff[2] ? pclk_gate_ff : `PCLK_GATE_RST;
            // RULE11: oscillator kept in stop by option
            // RULE6: slow low-power option stops oscillator
            xtal_osc_en <= (state_ff[4] ?
                            mode_ctrl_ff[`MODE_KEEP_OSC_BIT] : ~state_ff[5]) &
                           ~(state_ff[1] & mode_ctrl_ff[`MODE_SLOW_LP_BIT]) &
                           ~(xtal_fail);
            pll_en      <= clk_cfg_ff[`CFG_PLL_EN_BIT] & xtal_ok_ff &
                           ~stop_like & ~xtal_fail &
                           ~(state_ff[1] & mode_ctrl_ff[`MODE_SLOW_LP_BIT]);
            // RULE5: USB clock from PLL alongside system clocks
            usb_clk_en  <= pll_locked & pll_en & ~stop_like;
            if (stop_like || xtal_fail || nxt_state != state_ff)
                // RULE3: fall back to RC on crystal loss
                sys_clk_src <= `SRC_RC;
            else if (state_ff[1] && mode_ctrl_ff[`MODE_SLOW_LP_BIT])
                // RULE6: slow mode on low-power clock
                sys_clk_src <= `SRC_LP;
            else if (pll_en && pll_locked)
                sys_clk_src <= `SRC_PLL;
            else if (xtal_ok_ff)
                sys_clk_src <= `SRC_XTAL;
            else
                sys_clk_src <= `SRC_RC;
        end
    end

    // RULE15: boot pins caught once after reset release
    always @(posedge clock) begin
        if (!resetn) begin
            boot_done_ff <= 1'b0;
            boot_sel     <= 2'h0;
        end else if (!boot_done_ff) begin
            boot_done_ff <= 1'b1;
            boot_sel     <= boot_pins;
        end
    end

    // Sticky status; set wins over write-one-to-clear
    always @* begin
        irq_set = 3'h0;
        irq_set[`IRQ_XTAL_FAIL]  = xtal_fail;
        irq_set[`IRQ_XTAL_READY] = stab_done;
        irq_set[`IRQ_WAKE]       = stop_like & (nxt_state == ST_RUN);
    end

    always @(posedge clock) begin
        if (!resetn) begin
            irq_stat_ff <= 3'h0;
            irq         <= 1'b0;
        end else begin
            if (wr_en && ph_addr_ff == `OFS_IRQ_STATUS)
                irq_stat_ff <= (irq_stat_ff & ~hwdata[2:0]) | irq_set;
            else
                irq_stat_ff <= irq_stat_ff | irq_set;
            // RULE3: interrupt on any masked status bit: crystal failure, ready or wake
            irq <= |(irq_stat_ff & irq_mask_ff);
        end
    end

endmodule

//--- logic/clock_power_regs.vh
// Register offsets, fields, reset values and timing counts for the
// clock and power mode controller. Included by clock_power_mode_control.v.
`ifndef CLOCK_POWER_REGS_VH
`define CLOCK_POWER_REGS_VH

// Register byte offsets
`define OFS_MODE_CTRL     12'h000
`define OFS_CLK_CFG       12'h004
`define OFS_PCLK_GATE     12'h008
`define OFS_STATUS        12'h00c
`define OFS_IRQ_STATUS    12'h010
`define OFS_IRQ_MASK      12'h014
`define OFS_XTAL_STAB     12'h018

// Mode control fields
`define MODE_GO_BIT       0
`define MODE_SEL_LSB      1
`define MODE_SEL_W        3
`define MODE_RUN          3'h0
`define MODE_SLOW         3'h1
`define MODE_PCG          3'h2
`define MODE_WFI          3'h3
`define MODE_STOP         3'h4
`define MODE_STANDBY      3'h5
`define MODE_SLOW_LP_BIT  4
`define MODE_KEEP_OSC_BIT 5
`define MODE_KEEP_FLSH_BIT 6
`define MODE_KEEP_REG_BIT 7
`define MODE_RTC_RUN_BIT  8

// Clock config fields
`define CFG_PLL_EN_BIT    0
`define CFG_MUL_LSB       1
`define CFG_MUL_W         4
`define CFG_HDIV_LSB      5
`define CFG_PDIV_LSB      7
`define CFG_UDIV_LSB      9
`define CFG_SRAM_BIT      12
`define CFG_LPSEL_BIT     13
`define CLK_CFG_RST       14'h0000

// Interrupt bits
`define IRQ_XTAL_FAIL     0
`define IRQ_XTAL_READY    1
`define IRQ_WAKE          2
`define IRQ_W             3

// Clock source encodings
`define SRC_RC            2'h0
`define SRC_XTAL          2'h1
`define SRC_PLL           2'h2
`define SRC_LP            2'h3

// Timing
`define XTAL_STAB_RST     16'h0400
`define XTAL_MISS_CYC     8'h40
`define PCLK_N            8
`define PCLK_GATE_RST     8'hff

`endif

//--- test/clock_power_checker.sv
// Port-level checker for the clock and power mode controller.
// Assumes a single clock domain and a synchronous active-low reset.
`timescale 1ns/1ps

module clock_power_checker (
    // Clock and reset
    input wire logic       clock,
    input wire logic       resetn,
    // Inputs watched
    input wire logic       xtal_clk_in,
    input wire logic       periph_irq,
    input wire logic       ext_wakeup,
    input wire logic       rtc_event,
    input wire logic       standby_wakeup_pin,
    input wire logic       regulator_disable_pin,
    input wire logic [1:0] boot_pins,
    // Outputs watched
    input wire logic       xtal_osc_en,
    input wire logic [1:0] sys_clk_src,
    input wire logic       cpu_clk_en,
    input wire logic       periph_clk_en,
    input wire logic       main_reg_en,
    input wire logic       lp_reg_en,
    input wire logic       core_power_en,
    input wire logic [1:0] boot_sel
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);

    logic       prev_ff;
    logic [6:0] miss_ff;

    // Quiet crystal cycles; only counted while the oscillator is enabled
    always @(posedge clock) begin
        prev_ff <= xtal_clk_in;
        if (!resetn || !xtal_osc_en || xtal_clk_in != prev_ff)
            miss_ff <= 7'h00;
        else if (miss_ff != 7'h7f)
            miss_ff <= miss_ff + 7'h01;
    end

    sequence back_to_run;
        ##[1:3] (cpu_clk_en && periph_clk_en);
    endsequence
    sequence powered_run;
        ##[1:3] (core_power_en && cpu_clk_en && periph_clk_en);
    endsequence

    reset_rc_a: assert property ($rose(resetn) |->
        sys_clk_src == 2'h0 && cpu_clk_en) else $error("not on rc");
    reset_xtal_a: assert property ($rose(resetn) |->
        xtal_osc_en) else $error("crystal not started");
    xtal_fail_a: assert property (miss_ff == 7'd64 |->
        ##[1:2] (sys_clk_src == 2'h0)) else $error("no fallback to rc");
    wfi_wake_a: assert property (
        (!cpu_clk_en && periph_clk_en && periph_irq) |-> back_to_run)
        else $error("wait mode not left");
    stop_clocks_a: assert property (
        !periph_clk_en |-> !cpu_clk_en) else $error("cpu runs in stop");
    stop_wake_a: assert property (
        (!periph_clk_en && core_power_en && (ext_wakeup || rtc_event))
        |-> back_to_run) else $error("stop mode not left");
    standby_refuse_a: assert property (
        regulator_disable_pin |-> core_power_en)
        else $error("standby with external supply");
    standby_wake_a: assert property (
        (!core_power_en && (standby_wakeup_pin || rtc_event))
        |-> powered_run) else $error("standby not left");
    reg_off_a: assert property (regulator_disable_pin |=>
        !main_reg_en && !lp_reg_en) else $error("regulator left on");
    boot_capture_a: assert property ($rose(resetn) |=>
        boot_sel == $past(boot_pins)) else $error("boot pins missed");
endmodule

bind clock_power_mode_control clock_power_checker u_chk (
    .clock(clock), .resetn(resetn), .xtal_clk_in(xtal_clk_in),
    .periph_irq(periph_irq), .ext_wakeup(ext_wakeup),
    .rtc_event(rtc_event), .standby_wakeup_pin(standby_wakeup_pin),
    .regulator_disable_pin(regulator_disable_pin),
    .boot_pins(boot_pins), .xtal_osc_en(xtal_osc_en),
    .sys_clk_src(sys_clk_src), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en), .main_reg_en(main_reg_en),
    .lp_reg_en(lp_reg_en), .core_power_en(core_power_en),
    .boot_sel(boot_sel));

//--- test/clock_power_mode_control_bench.sv
// Self-checking bench: AHB-Lite register access plus wake stimulus.
// Assumes a zero-wait slave; waits still poll hreadyout.
`timescale 1ns/1ps

module clock_power_mode_control_bench;
    logic        clock = 1'b0, resetn = 1'b0, hsel = 1'b0;
    logic        hwrite = 1'b0, xtal_kill = 1'b0, periph_irq = 1'b0;
    logic        ext_wakeup = 1'b0, rtc_event = 1'b0;
    logic        standby_wakeup_pin = 1'b0, regulator_disable_pin = 1'b0;
    logic [1:0]  htrans = 2'h0, boot_pins = 2'h2;
    logic [2:0]  hsize = 3'h2;
    logic [11:0] haddr = 12'h000;
    logic [31:0] hwdata = 32'h0, hrdata, r;
    logic        hreadyout, hresp, xtal_osc_en, pll_en, usb_clk_en, b;
    logic        cpu_clk_en, periph_clk_en, flash_en, main_reg_en, irq;
    logic        lp_reg_en, core_power_en, rtc_run;
    logic [3:0]  pll_mul;
    logic [1:0]  sys_clk_src, ahb_div, apb_div, boot_sel;
    logic [2:0]  usb_div;
    logic [7:0]  apb_clk_gate_en;
    wire         xtal_clk_in, pll_locked;
    wire         hready = hreadyout;
    int          n_fail = 0, compares = 0;

    clock_power_mode_control dut (
        .clock(clock), .resetn(resetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp),
        .xtal_clk_in(xtal_clk_in), .pll_locked(pll_locked),
        .periph_irq(periph_irq), .ext_wakeup(ext_wakeup),
        .rtc_event(rtc_event), .standby_wakeup_pin(standby_wakeup_pin),
        .regulator_disable_pin(regulator_disable_pin),
        .boot_pins(boot_pins), .xtal_osc_en(xtal_osc_en),
        .pll_en(pll_en), .pll_mul(pll_mul), .sys_clk_src(sys_clk_src),
        .ahb_div(ahb_div), .apb_div(apb_div), .usb_div(usb_div),
        .usb_clk_en(usb_clk_en), .cpu_clk_en(cpu_clk_en),
        .periph_clk_en(periph_clk_en),
        .apb_clk_gate_en(apb_clk_gate_en), .flash_en(flash_en),
        .main_reg_en(main_reg_en), .lp_reg_en(lp_reg_en),
        .core_power_en(core_power_en), .rtc_run(rtc_run),
        .boot_sel(boot_sel), .irq(irq));
    osc_wake_model partner (.clock(clock), .xtal_osc_en(xtal_osc_en),
        .pll_en(pll_en), .xtal_kill(xtal_kill),
        .xtal_clk_in(xtal_clk_in), .pll_locked(pll_locked));

    initial forever #2 clock = ~clock;

    task wt(input int n);
        repeat (n) @(posedge clock);
    endtask
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w;
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task rc(input logic [11:0] a, input logic [31:0] e, input string nm);
        xfer(1'b0, a, 32'h0);
        chk(nm, r, e);
    endtask
    task complete_run;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        wt(20000);
        n_fail++;
        complete_run;
    end

    initial begin
        wt(2);
        resetn <= 1'b1;
        wt(3);
        chk("src", {sys_clk_src, cpu_clk_en, xtal_osc_en}, 4'h3);
        chk("boot", boot_sel, 2'h2);
        rc(12'h018, 32'h400, "stab");
        rc(12'h008, 32'hff, "gates");
        wr(12'h100, 32'h5);
        rc(12'h100, 32'h0, "unmapped");
        chk("resp", hresp, 1'b0);
        wr(12'h018, 32'h4);
        wt(60);
        xfer(1'b0, 12'h00c, 32'h0);
        chk("xok", r[8], 1'b1);
        rc(12'h010, 32'h2, "ready");
        wr(12'h014, 32'h0);
        wt(2);
        b = irq;
        wr(12'h014, 32'h7);
        wt(2);
        chk("mask", b ^ irq, 1'b1);
        wr(12'h010, 32'h7);
        wt(2);
        rc(12'h010, 32'h0, "clear");
        chk("irq", irq, 1'b0);
        wr(12'h004, 32'h62b);
        wt(40);
        chk("cfg", {pll_en, pll_mul, ahb_div, apb_div, usb_div, usb_clk_en},
            {1'b1, 4'h5, 2'h1, 2'h1, 3'h3, 1'b1});
        chk("pllsrc", sys_clk_src, 2'h2);
        wr(12'h004, 32'h162b);
        wt(4);
        chk("sram", apb_div, 2'h0);
        wr(12'h008, 32'ha5);
        wr(12'h000, 32'h5);
        wt(4);
        chk("pcg", {cpu_clk_en, apb_clk_gate_en}, 9'h1a5);
        wr(12'h000, 32'h13);
        wt(4);
        chk("slow", {sys_clk_src, pll_en, xtal_osc_en}, 4'hc);
        wr(12'h000, 32'h1);
        wt(40);
        wr(12'h000, 32'h7);
        wt(4);
        chk("wfi", {cpu_clk_en, periph_clk_en}, 2'h1);
        wr(12'h000, 32'h1);
        wt(4);
        chk("hold", cpu_clk_en, 1'b0);
        periph_irq <= 1'b1;
        wt(3);
        periph_irq <= 1'b0;
        chk("wwake", cpu_clk_en, 1'b1);
        wr(12'h000, 32'h29);
        wt(4);
        chk("stop", {cpu_clk_en, periph_clk_en, xtal_osc_en,
            core_power_en, flash_en, main_reg_en}, 6'h0c);
        ext_wakeup <= 1'b1;
        wt(2);
        chk("swsrc", sys_clk_src, 2'h0);
        ext_wakeup <= 1'b0;
        wt(1);
        chk("swake", {cpu_clk_en, periph_clk_en}, 2'h3);
        wr(12'h000, 32'h1c9);
        wt(4);
        chk("rtc", {rtc_run, xtal_osc_en, flash_en, main_reg_en},
            4'hb);
        rtc_event <= 1'b1;
        wt(3);
        rtc_event <= 1'b0;
        chk("rwake", cpu_clk_en, 1'b1);
        wr(12'h000, 32'hb);
        wt(4);
        chk("sby", core_power_en, 1'b0);
        ext_wakeup <= 1'b1;
        wt(3);
        ext_wakeup <= 1'b0;
        chk("sbyhold", core_power_en, 1'b0);
        standby_wakeup_pin <= 1'b1;
        wt(3);
        standby_wakeup_pin <= 1'b0;
        chk("sbypin", core_power_en, 1'b1);
        wr(12'h000, 32'hb);
        wt(4);
        rtc_event <= 1'b1;
        wt(3);
        rtc_event <= 1'b0;
        chk("sbyrtc", core_power_en, 1'b1);
        regulator_disable_pin <= 1'b1;
        wt(3);
        chk("regoff", {main_reg_en, lp_reg_en}, 2'h0);
        wr(12'h000, 32'hb);
        wt(4);
        chk("nosby", core_power_en, 1'b1);
        regulator_disable_pin <= 1'b0;
        wt(3);
        chk("regon", main_reg_en, 1'b1);
        wt(40);
        xtal_kill <= 1'b1;
        wt(100);
        chk("fail", sys_clk_src, 2'h0);
        xfer(1'b0, 12'h010, 32'h0);
        chk("failirq", r[0], 1'b1);
        xtal_kill <= 1'b0;
        boot_pins <= 2'h1;
        resetn <= 1'b0;
        wt(2);
        resetn <= 1'b1;
        wt(3);
        chk("boot2", boot_sel, 2'h1);
        complete_run;
    end
endmodule

//--- test/osc_wake_model.sv
// Behavioural crystal oscillator and PLL answering the controller.
// Assumes the bench may kill the crystal to provoke a failure.
`timescale 1ns/1ps

module osc_wake_model (
    // Clock and controls
    input  wire logic clock,
    input  wire logic xtal_osc_en,
    input  wire logic pll_en,
    input  wire logic xtal_kill,
    // Oscillator answers
    output logic      xtal_clk_in = 1'b0,
    output logic      pll_locked = 1'b0
);
    logic [3:0] lock_ff = 4'h0;
    logic [1:0] div_ff = 2'h0;

    always @(posedge clock) begin
        div_ff <= div_ff + 2'h1;
        if (xtal_osc_en && !xtal_kill && div_ff == 2'h3)
            xtal_clk_in <= !xtal_clk_in;
    end

    always @(posedge clock) begin
        if (!pll_en)
            lock_ff <= 4'h0;
        else if (lock_ff != 4'hf)
            lock_ff <= lock_ff + 4'h1;
        pll_locked <= pll_en && lock_ff == 4'hf;
    end
endmodule
